/* File: hdl/pid_pkg.sv */
// Constants, helper functions and types shared by both ends of the identifier read port.
// Assumes a single 125 MHz system clock on each end and an open-drain two-wire bus.

package pid_pkg;

  localparam logic [6:0] CTRL_CODE = 7'h57;
  localparam logic RW_READ = 1'b1;
  localparam logic RW_WRITE = 1'b0;
  localparam logic [7:0] ID_BASE = 8'hF0;
  localparam logic [7:0] ID_TOP = 8'hF7;
  localparam int ID_BYTES = 8;
  localparam logic [7:0] FILL_BYTE = 8'hFF;
  localparam logic [15:0] ENCAP_MARK = 16'hFFFE;
  localparam logic [15:0] ENCAP_MARK_ALT = 16'hFFFF;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Generated bus clock for the controller end
  localparam longint CLK_HZ = 125000000;
  localparam longint SCL_HZ = 400000;
  localparam int SCL_QUARTER = int'(CLK_HZ / (4 * SCL_HZ));

  typedef enum {T_IDLE, T_CTRL, T_CTRL_ACK, T_ADDR, T_ADDR_ACK, T_HOLD, T_LOAD, T_TX, T_TX_ACK} pid_tgt_state_t;
  typedef enum {H_IDLE, H_START, H_SEND, H_RECV, H_RSTART, H_STOP} pid_ctl_state_t;
  typedef enum {ST_CTRL_W, ST_ADDR, ST_CTRL_R} pid_stage_t;

  // Advance within the protected block only
  function automatic logic [7:0] pid_next_ptr(input logic [7:0] p);
    pid_next_ptr = {p[7:3], 3'(p[2:0] + 3'h1)};
  endfunction : pid_next_ptr

  function automatic logic pid_in_block(input logic [7:0] a);
    pid_in_block = (a >= ID_BASE) && (a <= ID_TOP);
  endfunction : pid_in_block

  function automatic logic [63:0] pid_encap48(input logic [47:0] id);
    pid_encap48 = {id[47:24], ENCAP_MARK, id[23:0]};
  endfunction : pid_encap48

endpackage : pid_pkg

/* File: hdl/pid_if.sv */
// Open-drain two-wire bus joining the controller end and the target end.
// Released lines read high, as with external pull-ups.
`timescale 1ns/10ps

interface pid_if;
  logic ctl_scl_o;
  logic ctl_scl_oe;
  logic ctl_sda_o;
  logic ctl_sda_oe;
  logic tgt_sda_o;
  logic tgt_sda_oe;
  logic scl;
  logic sda;

  assign scl = !(ctl_scl_oe && !ctl_scl_o);
  assign sda = !((ctl_sda_oe && !ctl_sda_o) || (tgt_sda_oe && !tgt_sda_o));

  modport target (input scl, input sda, output tgt_sda_o, output tgt_sda_oe);
  modport controller (input sda, output ctl_scl_o, output ctl_scl_oe, output ctl_sda_o, output ctl_sda_oe);
endinterface : pid_if

/* File: hdl/pid_target.sv */
// Target end: read side of the protected 8-byte identifier block.
// Bus lines arrive asynchronously and are oversampled by the system clock.
`timescale 1ns/10ps

module pid_target
  import pid_pkg::*;
#(
  parameter int ID_BITS = 48,
  // Arbitrary neutral identifier values
  parameter logic [23:0] OUI = 24'h5A3C96,
  parameter logic [39:0] EXT = 40'h0123456789
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  input wire logic clk_en,
  // Two-wire bus
  pid_if.target bus,
  // Shared pointer and write-cycle status
  input wire logic nvm_busy,
  input wire logic ptr_load,
  input wire logic [7:0] ptr_value,
  output logic [7:0] ptr,
  output logic read_active
);

  generate
    if (ID_BITS != 48 && ID_BITS != 64) begin : g_bad_bits
      $error("ID_BITS must be 48 or 64");
    end
    if (ID_BITS == 64 && (EXT[39:24] == ENCAP_MARK || EXT[39:24] == ENCAP_MARK_ALT)) begin : g_bad_ext
      $error("64-bit extension must not start with a reserved value");
    end
  endgenerate

  // Factory content, fixed at build time
  function automatic logic [7:0] id_byte(input int idx);
    if (ID_BITS == 64) begin
      if (idx < 3) begin
        id_byte = OUI[8*(2-idx) +: 8];
      end else begin
        id_byte = EXT[8*(7-idx) +: 8];
      end
    end else begin
      if (idx < 2) begin
        id_byte = FILL_BYTE;
      end else if (idx < 5) begin
        id_byte = OUI[8*(4-idx) +: 8];
      end else begin
        id_byte = EXT[8*(7-idx) +: 8];
      end
    end
  endfunction : id_byte

  // No write path: reads cannot disturb the stored identifier
  logic [7:0] id_mem [ID_BYTES];

  genvar g;
  generate
    for (g = 0; g < ID_BYTES; g++) begin : g_mem
      assign id_mem[g] = id_byte(g);
    end
  endgenerate

  // Synchronisers and edge detection
  logic scl_s1;
  logic scl_s2;
  logic scl_d;
  logic sda_s1;
  logic sda_s2;
  logic sda_d;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
    end else if (clk_en) begin
      scl_s1 <= bus.scl;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= bus.sda;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  assign scl_rise = scl_s2 && !scl_d;
  assign scl_fall = !scl_s2 && scl_d;
  assign bus_start = scl_s2 && scl_d && sda_d && !sda_s2;
  assign bus_stop = scl_s2 && scl_d && !sda_d && sda_s2;

  // Protocol state
  pid_tgt_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic rw;
  logic sda_low;

  logic ptr_set;
  logic ptr_step;
  logic [7:0] cur_byte;

  // Reads from a pointer left in the other space use its low bits
  assign cur_byte = id_mem[ptr[2:0]];
  assign ptr_set = clk_en && scl_fall && !bus_start && !bus_stop && state == T_ADDR && bit_cnt == BYTE_BITS
                   && pid_in_block(shift);
  assign ptr_step = clk_en && scl_rise && !bus_start && !bus_stop && state == T_TX_ACK;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state <= T_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      rw <= 1'b0;
      sda_low <= 1'b0;
    end else if (clk_en) begin
      if (bus_start) begin
        // Repeated Start drops a write phase but not the pointer
        state <= T_CTRL;
        bit_cnt <= 4'h0;
        sda_low <= 1'b0;
      end else if (bus_stop) begin
        state <= T_IDLE;
        sda_low <= 1'b0;
      end else if (scl_rise) begin
        unique case (state)
          T_CTRL, T_ADDR: begin
            if (bit_cnt != BYTE_BITS) begin
              shift <= {shift[6:0], sda_s2};
              bit_cnt <= 4'(bit_cnt + 4'h1);
            end
          end
          T_TX_ACK: begin
            if (!sda_s2) begin
              state <= T_LOAD;
            end else begin
              state <= T_IDLE;
            end
          end
          T_IDLE, T_CTRL_ACK, T_ADDR_ACK, T_HOLD, T_LOAD, T_TX: begin
          end
        endcase
      end else if (scl_fall) begin
        unique case (state)
          T_CTRL: begin
            if (bit_cnt == BYTE_BITS) begin
              bit_cnt <= 4'h0;
              // Busy write cycle hides the block entirely
              if (shift[7:1] == CTRL_CODE && !nvm_busy) begin
                rw <= shift[0];
                sda_low <= 1'b1;
                state <= T_CTRL_ACK;
              end else begin
                state <= T_IDLE;
              end
            end
          end
          T_CTRL_ACK: begin
            if (rw == RW_READ) begin
              sda_low <= !cur_byte[7];
              shift <= {cur_byte[6:0], 1'b0};
              bit_cnt <= 4'h1;
              state <= T_TX;
            end else begin
              sda_low <= 1'b0;
              state <= T_ADDR;
            end
          end
          T_ADDR: begin
            if (bit_cnt == BYTE_BITS) begin
              bit_cnt <= 4'h0;
              if (pid_in_block(shift)) begin
                sda_low <= 1'b1;
                state <= T_ADDR_ACK;
              end else begin
                state <= T_IDLE;
              end
            end
          end
          T_ADDR_ACK: begin
            // Data bytes of a write are not taken here
            sda_low <= 1'b0;
            state <= T_HOLD;
          end
          T_LOAD: begin
            sda_low <= !cur_byte[7];
            shift <= {cur_byte[6:0], 1'b0};
            bit_cnt <= 4'h1;
            state <= T_TX;
          end
          T_TX: begin
            if (bit_cnt == BYTE_BITS) begin
              // Free the line so the master can answer
              sda_low <= 1'b0;
              state <= T_TX_ACK;
            end else begin
              sda_low <= !shift[7];
              shift <= {shift[6:0], 1'b0};
              bit_cnt <= 4'(bit_cnt + 4'h1);
            end
          end
          T_IDLE, T_HOLD, T_TX_ACK: begin
          end
        endcase
      end
    end
  end

  // Single pointer also moved by the register and memory space
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ptr <= PTR_RESET;
    end else if (clk_en) begin
      if (ptr_set) begin
        ptr <= shift;
      end else if (ptr_step) begin
        ptr <= pid_next_ptr(ptr);
      end else if (ptr_load) begin
        ptr <= ptr_value;
      end
    end
  end

  assign bus.tgt_sda_o = 1'b0;
  assign bus.tgt_sda_oe = sda_low;
  assign read_active = (state == T_TX) || (state == T_TX_ACK) || (state == T_LOAD);

endmodule : pid_target

/* File: hdl/pid_master.sv */
// Controller end: random and sequential reads of the protected block.
// Drives the bus clock from a divider; the target is assumed never to stretch it.
`timescale 1ns/10ps

module pid_master
  import pid_pkg::*;
#(
  parameter int QUARTER = SCL_QUARTER
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  input wire logic clk_en,
  // Two-wire bus
  pid_if.controller bus,
  // Read command
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_addr,
  input wire logic [3:0] cmd_len,
  output logic cmd_ready,
  // Read results
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic done,
  output logic nack_err,
  output logic [63:0] id64
);

  generate
    if (QUARTER < 4 || QUARTER > 65536) begin : g_bad_quarter
      $error("QUARTER outside synchroniser latency or divider counter range");
    end
  endgenerate

  logic sda_s1;
  logic sda_s2;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else if (clk_en) begin
      sda_s1 <= bus.sda;
      sda_s2 <= sda_s1;
    end
  end

  pid_ctl_state_t state;
  pid_stage_t stage;
  logic [15:0] qcnt;
  logic [1:0] step;
  logic [3:0] bitn;
  logic [7:0] txb;
  logic [7:0] rxb;
  logic [7:0] addr;
  logic [3:0] remain;
  logic [47:0] id48;
  logic ack_in;
  logic scl_low;
  logic sda_low;
  logic tick;

  assign tick = (qcnt == 16'(QUARTER - 1));
  assign cmd_ready = (state == H_IDLE);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      qcnt <= 16'h0000;
      step <= 2'h0;
    end else if (clk_en) begin
      if (state == H_IDLE || tick) begin
        qcnt <= 16'h0000;
      end else begin
        qcnt <= 16'(qcnt + 16'h0001);
      end
      if (state == H_IDLE) begin
        step <= 2'h0;
      end else if (tick) begin
        step <= 2'(step + 2'h1);
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state <= H_IDLE;
      stage <= ST_CTRL_W;
      bitn <= 4'h0;
      txb <= 8'h00;
      rxb <= 8'h00;
      addr <= 8'h00;
      remain <= 4'h0;
      id48 <= 48'h0;
      id64 <= 64'h0;
      ack_in <= 1'b1;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      done <= 1'b0;
      nack_err <= 1'b0;
    end else if (clk_en) begin
      rd_valid <= 1'b0;
      done <= 1'b0;
      if (state == H_IDLE) begin
        if (cmd_valid) begin
          addr <= cmd_addr;
          remain <= (cmd_len == 4'h0) ? 4'h1 : cmd_len;
          nack_err <= 1'b0;
          state <= H_START;
        end
      end else if (tick) begin
        unique case (state)
          H_START: begin
            if (step == 2'h0) begin
              sda_low <= 1'b1;
            end else if (step == 2'h3) begin
              scl_low <= 1'b1;
              txb <= {CTRL_CODE, RW_WRITE};
              stage <= ST_CTRL_W;
              bitn <= 4'h0;
              state <= H_SEND;
            end
          end
          H_SEND: begin
            unique case (step)
              2'h0: sda_low <= (bitn != BYTE_BITS) && !txb[7];
              2'h1: scl_low <= 1'b0;
              2'h2: ack_in <= sda_s2;
              2'h3: begin
                scl_low <= 1'b1;
                txb <= {txb[6:0], 1'b0};
                bitn <= 4'(bitn + 4'h1);
                if (bitn == BYTE_BITS) begin
                  bitn <= 4'h0;
                  if (ack_in) begin
                    nack_err <= 1'b1;
                    state <= H_STOP;
                  end else begin
                    unique case (stage)
                      ST_CTRL_W: begin
                        txb <= addr;
                        stage <= ST_ADDR;
                      end
                      ST_ADDR: state <= H_RSTART;
                      ST_CTRL_R: state <= H_RECV;
                    endcase
                  end
                end
              end
            endcase
          end
          H_RSTART: begin
            unique case (step)
              2'h0: sda_low <= 1'b0;
              2'h1: scl_low <= 1'b0;
              2'h2: sda_low <= 1'b1;
              2'h3: begin
                scl_low <= 1'b1;
                txb <= {CTRL_CODE, RW_READ};
                stage <= ST_CTRL_R;
                state <= H_SEND;
              end
            endcase
          end
          H_RECV: begin
            unique case (step)
              2'h0: sda_low <= (bitn == BYTE_BITS) && (remain > 4'h1);
              2'h1: scl_low <= 1'b0;
              2'h2: begin
                if (bitn != BYTE_BITS) begin
                  rxb <= {rxb[6:0], sda_s2};
                end
              end
              2'h3: begin
                scl_low <= 1'b1;
                bitn <= 4'(bitn + 4'h1);
                if (bitn == BYTE_BITS) begin
                  bitn <= 4'h0;
                  rd_data <= rxb;
                  rd_valid <= 1'b1;
                  id48 <= {id48[39:0], rxb};
                  id64 <= pid_encap48({id48[39:0], rxb});
                  remain <= 4'(remain - 4'h1);
                  if (remain == 4'h1) begin
                    state <= H_STOP;
                  end
                end
              end
            endcase
          end
          H_STOP: begin
            unique case (step)
              2'h0: sda_low <= 1'b1;
              2'h1: scl_low <= 1'b0;
              2'h2: sda_low <= 1'b0;
              2'h3: begin
                done <= 1'b1;
                state <= H_IDLE;
              end
            endcase
          end
          H_IDLE: begin
          end
        endcase
      end
    end
  end

  assign bus.ctl_scl_o = 1'b0;
  assign bus.ctl_scl_oe = scl_low;
  assign bus.ctl_sda_o = 1'b0;
  assign bus.ctl_sda_oe = sda_low;

endmodule : pid_master

/* File: sim/pid_monitor.sv */
// Link checker: watches the shared two-wire lines between the two ends.
// Assumes both ends and this checker run on one system clock and reset.
`timescale 1ns/10ps

module pid_monitor
  import pid_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Link lines
  input wire logic ctl_scl_o,
  input wire logic ctl_scl_oe,
  input wire logic ctl_sda_o,
  input wire logic ctl_sda_oe,
  input wire logic tgt_sda_o,
  input wire logic tgt_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q;
  logic sda_q;
  logic rd;
  logic nacked;
  logic [3:0] bitn;
  logic [1:0] byten;
  logic [7:0] shreg;
  logic rise;
  logic start_c;
  logic stop_c;
  logic ack_slot;

  assign rise = scl && !scl_q;
  assign start_c = scl && scl_q && sda_q && !sda;
  assign stop_c = scl && scl_q && !sda_q && sda;
  assign ack_slot = rise && bitn == 4'h8;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      shreg <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (rise) begin
        shreg <= {shreg[6:0], sda};
      end
    end
  end

  // Bit and byte position since the last Start or Stop
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      bitn <= 4'h0;
      byten <= 2'h0;
    end else if (start_c || stop_c) begin
      bitn <= 4'h0;
      byten <= 2'h0;
    end else if (rise) begin
      bitn <= (bitn == 4'h9) ? 4'h1 : bitn + 4'h1;
      if (bitn == 4'h9 && byten != 2'h3) begin
        byten <= byten + 2'h1;
      end
    end
  end

  // Read phase and nack seen in it
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rd <= 1'b0;
      nacked <= 1'b0;
    end else if (start_c) begin
      rd <= 1'b0;
      nacked <= 1'b0;
    end else if (ack_slot) begin
      if (byten == 2'h0 && !sda && shreg[0]) begin
        rd <= 1'b1;
      end
      if (rd && byten != 2'h0 && sda) begin
        nacked <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  property p_od_low;
    (tgt_sda_oe || ctl_sda_oe || ctl_scl_oe) |-> !(tgt_sda_o || ctl_sda_o || ctl_scl_o);
  endproperty
  a_od_low: assert property (p_od_low) else $error("open-drain output driven high");
  // Outside the read phase the target may only pull the ack bit
  property p_wr_quiet;
    rise && bitn != 4'h8 && !rd |-> !tgt_sda_oe;
  endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("target drove a bit it should only receive");
  property p_ctrl_code;
    ack_slot && byten == 2'h0 && !sda |-> shreg[7:1] == CTRL_CODE;
  endproperty
  a_ctrl_code: assert property (p_ctrl_code) else $error("foreign control byte acknowledged");
  property p_read_ack;
    ack_slot && byten == 2'h0 && shreg == {CTRL_CODE, RW_READ} |-> !sda;
  endproperty
  a_read_ack: assert property (p_read_ack) else $error("read control byte not acknowledged");
  property p_addr_range;
    ack_slot && byten == 2'h1 && !rd && !sda |-> shreg >= ID_BASE && shreg <= ID_TOP;
  endproperty
  a_addr_range: assert property (p_addr_range) else $error("address outside block acknowledged");
  property p_tgt_hold;
    scl && scl_q |-> $stable(tgt_sda_oe);
  endproperty
  a_tgt_hold: assert property (p_tgt_hold) else $error("target data moved while clock high");
  property p_start_free;
    start_c |-> !tgt_sda_oe;
  endproperty
  a_start_free: assert property (p_start_free) else $error("target holds data line at Start");
  property p_stop_free;
    stop_c |=> !tgt_sda_oe [*8];
  endproperty
  a_stop_free: assert property (p_stop_free) else $error("target drives after Stop");
  property p_nack_free;
    nacked |-> !tgt_sda_oe;
  endproperty
  a_nack_free: assert property (p_nack_free) else $error("target drives after nack");

  c_read: cover property (ack_slot && byten == 2'h0 && rd);
  c_long: cover property (ack_slot && byten == 2'h3 && rd && !sda);
  c_nack: cover property ($rose(nacked));
endmodule : pid_monitor

/* File: sim/protected_id_memory_read_port_tb.sv */
// Testbench: controller end reads the target end across the shared link.
// Assumes a shortened bus clock; the main pair uses the 48-bit identifier variant, a second pair the 64-bit one.
`timescale 1ns/10ps

module protected_id_memory_read_port_tb;
  import pid_pkg::*;
  localparam logic [23:0] T_OUI = 24'h5A3C96;
  localparam logic [23:0] T_EXT = 24'h456789;
  localparam logic [39:0] T_EXT64 = 40'h13579BDF02;
  // Upper two bytes unprogrammed in this variant
  localparam logic [63:0] MEM48 = {16'hFFFF, T_OUI, T_EXT};
  logic clock, reset, clk_en, cmd_valid, cmd_ready, rd_valid, done, nack_err;
  logic nvm_busy, ptr_load, read_active;
  logic [7:0] cmd_addr, rd_data, ptr_value, ptr;
  logic [3:0] cmd_len;
  logic [63:0] id64;
  logic cmd_valid64, rd_valid64, done64;
  logic [7:0] rd_data64;
  int err_total, tests_run, cycles;

  pid_if pid_if_inst();
  pid_master #(.QUARTER(8)) pid_master_inst(.clock(clock), .reset(reset), .clk_en(clk_en),
    .bus(pid_if_inst.controller), .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
    .cmd_ready(cmd_ready), .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .nack_err(nack_err), .id64(id64));
  pid_target #(.ID_BITS(48), .OUI(T_OUI), .EXT({16'h0000, T_EXT})) pid_target_inst(.clock(clock),
    .reset(reset), .clk_en(clk_en), .bus(pid_if_inst.target), .nvm_busy(nvm_busy), .ptr_load(ptr_load),
    .ptr_value(ptr_value), .ptr(ptr), .read_active(read_active));
  pid_monitor pid_monitor_inst(.clock(clock), .reset(reset), .ctl_scl_o(pid_if_inst.ctl_scl_o),
    .ctl_scl_oe(pid_if_inst.ctl_scl_oe), .ctl_sda_o(pid_if_inst.ctl_sda_o), .ctl_sda_oe(pid_if_inst.ctl_sda_oe),
    .tgt_sda_o(pid_if_inst.tgt_sda_o), .tgt_sda_oe(pid_if_inst.tgt_sda_oe), .scl(pid_if_inst.scl),
    .sda(pid_if_inst.sda));

  // Second pair on the 64-bit variant, same clock and reset
  if (1) begin : g_wide
    pid_if pid_if_inst();
    pid_master #(.QUARTER(8)) pid_master_inst(.clock(clock), .reset(reset), .clk_en(clk_en),
      .bus(pid_if_inst.controller), .cmd_valid(cmd_valid64), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
      .cmd_ready(), .rd_valid(rd_valid64), .rd_data(rd_data64), .done(done64), .nack_err(), .id64());
    pid_target #(.ID_BITS(64), .OUI(T_OUI), .EXT(T_EXT64)) pid_target_inst(.clock(clock),
      .reset(reset), .clk_en(clk_en), .bus(pid_if_inst.target), .nvm_busy(nvm_busy), .ptr_load(ptr_load),
      .ptr_value(ptr_value), .ptr(), .read_active());
  end

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  function automatic logic [7:0] exp_byte(input logic [7:0] a);
    logic [63:0] t;
    t = MEM48 >> (8 * (7 - a[2:0]));
    return t[7:0];
  endfunction : exp_byte

  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : chk

  task automatic final_report;
    if (err_total == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  // One command, every returned byte judged against the stored image
  task automatic run_read(input logic [7:0] a, input logic [3:0] n, input logic bad);
    logic [7:0] p;
    int got;
    int w;
    p = a;
    got = 0;
    w = 0;
    @(negedge clock);
    cmd_addr = a;
    cmd_len = n;
    cmd_valid = 1'b1;
    @(negedge clock);
    cmd_valid = 1'b0;
    chk("cmd_ready", 1'b0, cmd_ready);
    while (done !== 1'b1 && w < 20000) begin
      @(negedge clock);
      w++;
      if (rd_valid === 1'b1) begin
        chk("rd_data", exp_byte(p), rd_data);
        chk("read_active", got + 1 < n, read_active);
        p = {p[7:3], 3'(p[2:0] + 3'h1)};
        got++;
      end
    end
    chk("byte count", bad ? 0 : ((n == 4'h0) ? 1 : n), got);
    chk("nack_err", bad, nack_err);
    chk("read_active", 1'b0, read_active);
    chk("cmd_ready", 1'b1, cmd_ready);
    if (!bad) begin
      chk("ptr", p, ptr);
    end
  endtask : run_read

  task automatic t_random;
    repeat (2) run_read(8'hF2, 4'h1, 1'b0);
  endtask : t_random

  task automatic t_seq_wrap;
    run_read(8'hF6, 4'h4, 1'b0);
    run_read(8'hF0, 4'h8, 1'b0);
    chk("id64", {T_OUI, 16'hFFFE, T_EXT}, id64);
    run_read(8'hF7, 4'h0, 1'b0);
  endtask : t_seq_wrap

  task automatic t_refuse;
    logic [7:0] outside [3];
    outside = '{8'h10, 8'hEF, 8'hF8};
    foreach (outside[i]) run_read(outside[i], 4'h1, 1'b1);
  endtask : t_refuse

  task automatic t_busy;
    @(negedge clock);
    nvm_busy = 1'b1;
    run_read(8'hF3, 4'h1, 1'b1);
    nvm_busy = 1'b0;
  endtask : t_busy

  task automatic t_shared;
    @(negedge clock);
    ptr_value = 8'h25;
    ptr_load = 1'b1;
    @(negedge clock);
    ptr_load = 1'b0;
    @(negedge clock);
    chk("ptr", 8'h25, ptr);
    // Clock enable low must hold off even the side load
    clk_en = 1'b0;
    ptr_value = 8'h33;
    ptr_load = 1'b1;
    @(negedge clock);
    @(negedge clock);
    chk("ptr frozen", 8'h25, ptr);
    ptr_load = 1'b0;
    clk_en = 1'b1;
    run_read(8'hF4, 4'h2, 1'b0);
  endtask : t_shared

  // 64-bit variant: all eight locations carry the identifier
  task automatic t_wide;
    logic [63:0] img;
    int w;
    img = 64'h0;
    w = 0;
    @(negedge clock);
    cmd_addr = ID_BASE;
    cmd_len = 4'h8;
    cmd_valid64 = 1'b1;
    @(negedge clock);
    cmd_valid64 = 1'b0;
    while (done64 !== 1'b1 && w < 20000) begin
      @(negedge clock);
      w++;
      if (rd_valid64 === 1'b1) begin
        img = {img[55:0], rd_data64};
      end
    end
    chk("id image", {T_OUI, T_EXT64}, img);
  endtask : t_wide

  // Hang guard: the whole sequence needs about 16200 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      final_report();
    end
  end

  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    cmd_valid = 1'b0;
    cmd_addr = 8'h00;
    cmd_valid64 = 1'b0;
    cmd_len = 4'h0;
    nvm_busy = 1'b0;
    ptr_load = 1'b0;
    ptr_value = 8'h00;
    err_total = 0;
    tests_run = 0;
    cycles = 0;
    repeat (3) @(negedge clock);
    reset = 1'b0;
    t_random();
    t_seq_wrap();
    t_refuse();
    t_busy();
    t_shared();
    t_wide();
    final_report();
  end
endmodule : protected_id_memory_read_port_tb
